// ### core/scb_pkg.sv
// Constants, types and helpers for the system control register bank.
// Assumes a single core_clk domain and an AHB-Lite master in front.
//
// Notes on behaviour
// - enable A bit 3 passes the PWM event flag as an interrupt request.
// - enable A bit 2 with any of three capture flags raises capture request.
// - enable A bit 1 with any pin flag raises the pin request.
// - enable A bit 0 with I2C event or timeout flag raises I2C request.
// - enable B bit 2 forwards the wake timer flag.
// - enable B bit 1 forwards the timer 3 overflow flag.
// - enable B bit 0 with second UART tx or rx done raises its request.
// - trigger with bad address, bad command or locked block sets fault bit 6.
// - erase or program below brown-out with guard, detect on, reset off faults.
// - fault flag stays set until software writes it to zero.
// - chip control bit 0 enables self-programming and the fast oscillator.
// - boot select bit 1 picks application flash at 0, loader flash at 1.
// - port 2 bits 7 to 1 always read zero.
// - port 2 bit 0 shows its pin only when reset pin disable config is 0.
// - software reset sets auxiliary bit 7.
// - external reset pin sets auxiliary bit 6.
// - program counter overrun resets the device and sets auxiliary bit 5.
// - in debug mode with reset allow 0, overrun only sets the flag.
// - auxiliary bit 3 is a plain user flag.
// - swap bit 2 exchanges UART0 receive and transmit pins at once.
// - programming trigger clears itself on completion and always reads 0.
package scb_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE_A = 8'h9B;
  localparam logic [7:0] IDX_ENABLE_B = 8'h9C;
  localparam logic [7:0] IDX_CHIP_CONTROL = 8'h9F;
  localparam logic [7:0] IDX_PORT2 = 8'hA0;
  localparam logic [7:0] IDX_AUX = 8'hA2;
  localparam logic [7:0] IDX_PROG_TRIGGER = 8'hA4;
  // enable A fields
  localparam int BIT_PWM_EN = 3;
  localparam int BIT_CAP_EN = 2;
  localparam int BIT_PIN_EN = 1;
  localparam int BIT_I2C_EN = 0;
  // enable B fields
  localparam int BIT_WKT_EN = 2;
  localparam int BIT_T3_EN = 1;
  localparam int BIT_UART1_EN = 0;
  localparam logic [7:0] ENABLE_B_MASK = 8'h07;
  // chip control fields
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_PROG_FAULT = 6;
  localparam int BIT_BOOT_SEL = 1;
  localparam int BIT_PROG_ENABLE = 0;
  // auxiliary fields
  localparam int BIT_SOFT_RST_FLAG = 7;
  localparam int BIT_PIN_RST_FLAG = 6;
  localparam int BIT_OVERRUN_FLAG = 5;
  localparam int BIT_USER_FLAG2 = 3;
  localparam int BIT_UART0_SWAP = 2;
  // trigger field
  localparam int BIT_PROG_TRIGGER = 0;
  // reset values
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_CHIP_CONTROL = 8'h00;
  localparam logic [7:0] RESET_AUX = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RDWAIT = 2'b10
  } scb_bus_state_t;

  // request is enable gated by any flag set
  function automatic logic scb_gate(input logic en, input logic [7:0] flags);
    scb_gate = en & (|flags);
  endfunction
endpackage : scb_pkg

// ### core/scb_irq_gate.sv
// Interrupt request gating for the peripheral enables.
// Assumes flags arrive synchronous to core_clk from their peripherals.
module scb_irq_gate
  import scb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] enable_a,
  input wire logic [7:0] enable_b,
  input wire logic pwm_event_flag,
  input wire logic [2:0] capture_flags,
  input wire logic [7:0] pin_flag_register,
  input wire logic i2c_event_flag,
  input wire logic i2c_timeout_flag,
  input wire logic wake_timer_flag,
  input wire logic timer3_overflow_flag,
  input wire logic uart1_tx_done_flag,
  input wire logic uart1_rx_done_flag,
  output logic [6:0] irq_req
);
  // one registered request per source, recomputed every cycle
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      irq_req <= 7'h00;
    end
    else
    begin
      irq_req[0] <= scb_gate(enable_a[BIT_PWM_EN], {7'h00, pwm_event_flag});
      irq_req[1] <= scb_gate(enable_a[BIT_CAP_EN], {5'h00, capture_flags});
      irq_req[2] <= scb_gate(enable_a[BIT_PIN_EN], pin_flag_register);
      irq_req[3] <= scb_gate(enable_a[BIT_I2C_EN],
        {6'h00, i2c_timeout_flag, i2c_event_flag});
      irq_req[4] <= scb_gate(enable_b[BIT_WKT_EN], {7'h00, wake_timer_flag});
      irq_req[5] <= scb_gate(enable_b[BIT_T3_EN],
        {7'h00, timer3_overflow_flag});
      irq_req[6] <= scb_gate(enable_b[BIT_UART1_EN],
        {6'h00, uart1_rx_done_flag, uart1_tx_done_flag});
    end
  end

  property p_capture_req;
    @(posedge core_clk) disable iff (srst)
    enable_a[BIT_CAP_EN] && (|capture_flags) |=> irq_req[1];
  endproperty
  a_capture_req: assert property (p_capture_req)
    else $error("capture request missing");

  property p_pwm_blocked;
    @(posedge core_clk) disable iff (srst)
    !enable_a[BIT_PWM_EN] |=> !irq_req[0];
  endproperty
  a_pwm_blocked: assert property (p_pwm_blocked)
    else $error("pwm request not blocked");

  property p_uart1_req;
    @(posedge core_clk) disable iff (srst)
    ##1 irq_req[6] == $past(enable_b[BIT_UART1_EN]
      && (uart1_tx_done_flag || uart1_rx_done_flag));
  endproperty
  a_uart1_req: assert property (p_uart1_req)
    else $error("uart1 request wrong");
endmodule // scb_irq_gate

// ### core/scb_prog_check.sv
// Fault detection for self-programming requests.
// Assumes the sequencer reports range, command and lock checks as levels.
module scb_prog_check
  import scb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic prog_start,
  input wire logic prog_addr_oversize,
  input wire logic prog_cmd_invalid,
  input wire logic prog_block_locked,
  input wire logic prog_erase_active,
  input wire logic below_brownout,
  input wire logic brownout_prog_guard,
  input wire logic brownout_detect_enable,
  input wire logic brownout_reset_enable,
  output logic fault_set
);
  logic bad_request;
  logic brownout_hazard;

  // request checks only count in the trigger cycle
  assign bad_request = prog_start
    && (prog_addr_oversize || prog_cmd_invalid || prog_block_locked);
  // with brown-out reset off, a low supply would corrupt flash silently
  assign brownout_hazard = prog_erase_active && below_brownout
    && brownout_prog_guard && brownout_detect_enable
    && !brownout_reset_enable;

  // registered set pulse toward the fault flag; stays high while the brown-out hazard lasts
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fault_set <= 1'b0;
    end
    else
    begin
      fault_set <= bad_request || brownout_hazard;
    end
  end

  property p_brownout_fault;
    @(posedge core_clk) disable iff (srst)
    prog_erase_active && below_brownout && brownout_prog_guard
      && brownout_detect_enable && !brownout_reset_enable |=> fault_set;
  endproperty
  a_brownout_fault: assert property (p_brownout_fault)
    else $error("brown-out fault not raised");

  property p_no_spurious_fault;
    @(posedge core_clk) disable iff (srst)
    !prog_start && !prog_erase_active |=> !fault_set;
  endproperty
  a_no_spurious_fault: assert property (p_no_spurious_fault)
    else $error("fault raised with no cause");
endmodule // scb_prog_check

// ### core/scb_bank.sv
// System control register bank behind an AHB-Lite slave port.
// Assumes a single master, word-sized single transfers, hready = hreadyout.
module scb_bank
  import scb_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic pwm_event_flag,
  input wire logic [2:0] capture_flags,
  input wire logic [7:0] pin_flag_register,
  input wire logic i2c_event_flag,
  input wire logic i2c_timeout_flag,
  input wire logic wake_timer_flag,
  input wire logic timer3_overflow_flag,
  input wire logic uart1_tx_done_flag,
  input wire logic uart1_rx_done_flag,
  output logic [6:0] irq_req,
  input wire logic prog_addr_oversize,
  input wire logic prog_cmd_invalid,
  input wire logic prog_block_locked,
  input wire logic prog_done,
  input wire logic prog_erase_active,
  input wire logic below_brownout,
  input wire logic brownout_prog_guard,
  input wire logic brownout_detect_enable,
  input wire logic brownout_reset_enable,
  output logic prog_trigger,
  output logic fast_internal_osc_on,
  output logic boot_from_loader,
  output logic soft_reset_req,
  input wire logic port2_bit0,
  input wire logic reset_pin_disable_cfg,
  input wire logic soft_reset_event,
  input wire logic pin_reset_event,
  input wire logic pc_overrun,
  input wire logic on_chip_debug_mode,
  input wire logic debug_reset_allow,
  output logic overrun_reset_req,
  input wire logic uart0_txd,
  input wire logic p06_in,
  input wire logic p07_in,
  output logic uart0_rxd,
  output logic p06_out,
  output logic p07_out,
  output logic p06_oe,
  output logic p07_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // storage and bus state
  logic [7:0] peripheral_int_enable_a;
  logic [7:0] peripheral_int_enable_b;
  logic [7:0] chip_control;
  logic [7:0] reset_source_aux;
  scb_bus_state_t bus_state;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic rd_ok;
  logic wr_ok;
  logic addr_take;
  logic addr_mapped;
  logic [7:0] next_chip_control;
  logic [7:0] next_aux;
  logic [7:0] wdata;
  logic fault_set;
  logic prog_start;
  logic hrdata_load;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign addr_take = hsel && (htrans == HTRANS_NONSEQ) && hready;
  // only the low ten address bits carry registers; the rest must be zero
  assign addr_mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'b00);
  assign wdata = hwdata[7:0];

  // write strobe in the data phase of an accepted write
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_pend && wr_ok && (wr_idx == idx);
  endfunction

  // read value of one register, narrow data in the low byte
  function automatic logic [7:0] reg_value(input logic [7:0] idx);
    unique case (idx)
      IDX_ENABLE_A: reg_value = peripheral_int_enable_a;
      IDX_ENABLE_B: reg_value = peripheral_int_enable_b & ENABLE_B_MASK;
      // soft reset bit is write-only
      IDX_CHIP_CONTROL: reg_value = {1'b0, chip_control[6:0]};
      IDX_PORT2: reg_value = {7'h00, port2_bit0 & !reset_pin_disable_cfg};
      IDX_AUX: reg_value = {reset_source_aux[7:2], 2'b00};
      IDX_PROG_TRIGGER: reg_value = 8'h00;
      default: reg_value = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: writes with no wait, reads with one wait state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      bus_state <= BUS_IDLE;
      hreadyout <= 1'b1;
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      wr_ok <= 1'b0;
      rd_idx <= 8'h00;
      rd_ok <= 1'b0;
    end
    else
    begin
      unique case (bus_state)
        BUS_IDLE:
        begin
          wr_pend <= addr_take && hwrite;
          wr_idx <= haddr[9:2];
          wr_ok <= addr_mapped;
          if (addr_take && !hwrite)
          begin
            // wait state lets a preceding write land before the read mux
            rd_idx <= haddr[9:2];
            rd_ok <= addr_mapped;
            bus_state <= BUS_RDWAIT;
            hreadyout <= 1'b0;
          end
        end
        BUS_RDWAIT:
        begin
          wr_pend <= 1'b0;
          bus_state <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  assign hrdata_load = (bus_state == BUS_RDWAIT);

  // read data, zero for unmapped addresses
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hrdata <= 32'h00000000;
    end
    else if (hrdata_load)
    begin
      hrdata <= rd_ok ? {24'h000000, reg_value(rd_idx)} : 32'h00000000;
    end
  end

  // the response is always okay
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt enables; upper bits of A are kept for other peripherals
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      peripheral_int_enable_a <= RESET_ENABLE;
      peripheral_int_enable_b <= RESET_ENABLE;
    end
    else
    begin
      if (wr_hit(IDX_ENABLE_A))
      begin
        peripheral_int_enable_a <= wdata;
      end
      if (wr_hit(IDX_ENABLE_B))
      begin
        peripheral_int_enable_b <= wdata & ENABLE_B_MASK;
      end
    end
  end

  scb_irq_gate u_irq_gate (
    .core_clk(core_clk),
    .srst(srst),
    .enable_a(peripheral_int_enable_a),
    .enable_b(peripheral_int_enable_b),
    .pwm_event_flag(pwm_event_flag),
    .capture_flags(capture_flags),
    .pin_flag_register(pin_flag_register),
    .i2c_event_flag(i2c_event_flag),
    .i2c_timeout_flag(i2c_timeout_flag),
    .wake_timer_flag(wake_timer_flag),
    .timer3_overflow_flag(timer3_overflow_flag),
    .uart1_tx_done_flag(uart1_tx_done_flag),
    .uart1_rx_done_flag(uart1_rx_done_flag),
    .irq_req(irq_req)
  );

  ////////////////////////////////////////////////////////////////////////////
  // chip control: fault flag, boot select, programming enable
  always_comb
  begin
    next_chip_control = chip_control;
    next_chip_control[BIT_SOFT_RESET] = 1'b0;
    if (wr_hit(IDX_CHIP_CONTROL))
    begin
      next_chip_control[BIT_BOOT_SEL] = wdata[BIT_BOOT_SEL];
      next_chip_control[BIT_PROG_ENABLE] = wdata[BIT_PROG_ENABLE];
      // writing zero clears the fault; writing one leaves it alone
      if (!wdata[BIT_PROG_FAULT])
      begin
        next_chip_control[BIT_PROG_FAULT] = 1'b0;
      end
    end
    // a new fault wins over a clear in the same cycle
    if (fault_set)
    begin
      next_chip_control[BIT_PROG_FAULT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      chip_control <= RESET_CHIP_CONTROL;
    end
    else
    begin
      chip_control <= next_chip_control;
    end
  end

  // control outputs, each from its own flop
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      fast_internal_osc_on <= 1'b0;
      boot_from_loader <= 1'b0;
      soft_reset_req <= 1'b0;
    end
    else
    begin
      // oscillator follows the enable; it stops only when software clears it
      fast_internal_osc_on <= chip_control[BIT_PROG_ENABLE];
      boot_from_loader <= chip_control[BIT_BOOT_SEL];
      soft_reset_req <= wr_hit(IDX_CHIP_CONTROL) && wdata[BIT_SOFT_RESET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming trigger: accepted only while programming is enabled
  assign prog_start = wr_hit(IDX_PROG_TRIGGER) && wdata[BIT_PROG_TRIGGER]
    && chip_control[BIT_PROG_ENABLE] && !prog_trigger;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      prog_trigger <= 1'b0;
    end
    else if (prog_start)
    begin
      prog_trigger <= 1'b1;
    end
    else if (prog_done)
    begin
      prog_trigger <= 1'b0;
    end
  end

  scb_prog_check u_prog_check (
    .core_clk(core_clk),
    .srst(srst),
    .prog_start(prog_start),
    .prog_addr_oversize(prog_addr_oversize),
    .prog_cmd_invalid(prog_cmd_invalid),
    .prog_block_locked(prog_block_locked),
    .prog_erase_active(prog_erase_active),
    .below_brownout(below_brownout),
    .brownout_prog_guard(brownout_prog_guard),
    .brownout_detect_enable(brownout_detect_enable),
    .brownout_reset_enable(brownout_reset_enable),
    .fault_set(fault_set)
  );

  ////////////////////////////////////////////////////////////////////////////
  // auxiliary: reset cause flags, user flag, uart0 swap
  always_comb
  begin
    next_aux = reset_source_aux;
    if (wr_hit(IDX_AUX))
    begin
      next_aux = {wdata[7:5], 1'b0, wdata[BIT_USER_FLAG2],
        wdata[BIT_UART0_SWAP], 2'b00};
    end
    // hardware sets win over a software write in the same cycle
    if (soft_reset_event)
    begin
      next_aux[BIT_SOFT_RST_FLAG] = 1'b1;
    end
    if (pin_reset_event)
    begin
      next_aux[BIT_PIN_RST_FLAG] = 1'b1;
    end
    if (pc_overrun)
    begin
      next_aux[BIT_OVERRUN_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      reset_source_aux <= RESET_AUX;
    end
    else
    begin
      reset_source_aux <= next_aux;
    end
  end

  // overrun reset is held off while a debugger owns the core and debug reset is not allowed
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      overrun_reset_req <= 1'b0;
    end
    else
    begin
      overrun_reset_req <= pc_overrun
        && !(on_chip_debug_mode && !debug_reset_allow);
    end
  end

  // pin swap takes effect at once; a mid-frame swap corrupts the frame
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      uart0_rxd <= 1'b1;
      p06_out <= 1'b1;
      p07_out <= 1'b1;
      p06_oe <= 1'b0;
      p07_oe <= 1'b0;
    end
    else
    begin
      uart0_rxd <= next_aux[BIT_UART0_SWAP] ? p06_in : p07_in;
      p06_out <= uart0_txd;
      p07_out <= uart0_txd;
      p06_oe <= !next_aux[BIT_UART0_SWAP];
      p07_oe <= next_aux[BIT_UART0_SWAP];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fault_set;
    @(posedge core_clk) disable iff (srst)
    fault_set |=> chip_control[BIT_PROG_FAULT];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not set");

  property p_fault_sticky;
    @(posedge core_clk) disable iff (srst)
    chip_control[BIT_PROG_FAULT]
      && !(wr_pend && wr_ok && (wr_idx == IDX_CHIP_CONTROL))
      |=> chip_control[BIT_PROG_FAULT];
  endproperty
  a_fault_sticky: assert property (p_fault_sticky)
    else $error("fault flag cleared by hardware");

  property p_osc_follows;
    @(posedge core_clk) disable iff (srst)
    $rose(chip_control[BIT_PROG_ENABLE]) |=> fast_internal_osc_on [*2];
  endproperty
  a_osc_follows: assert property (p_osc_follows)
    else $error("oscillator not on with programming enabled");

  property p_boot_sel;
    @(posedge core_clk) disable iff (srst)
    ##1 boot_from_loader == $past(chip_control[BIT_BOOT_SEL]);
  endproperty
  a_boot_sel: assert property (p_boot_sel)
    else $error("boot select mismatch");

  property p_port2_read;
    @(posedge core_clk) disable iff (srst)
    hrdata_load && rd_ok && (rd_idx == IDX_PORT2) |=> (hrdata[31:1] == 0)
      && (hrdata[0] == $past(port2_bit0 && !reset_pin_disable_cfg));
  endproperty
  a_port2_read: assert property (p_port2_read)
    else $error("port 2 read value wrong");

  property p_overrun_flag;
    @(posedge core_clk) disable iff (srst)
    pc_overrun |=> reset_source_aux[BIT_OVERRUN_FLAG];
  endproperty
  a_overrun_flag: assert property (p_overrun_flag)
    else $error("overrun flag not set");

  property p_overrun_debug;
    @(posedge core_clk) disable iff (srst)
    pc_overrun && on_chip_debug_mode && !debug_reset_allow
      |=> !overrun_reset_req;
  endproperty
  a_overrun_debug: assert property (p_overrun_debug)
    else $error("overrun reset not suppressed in debug");

  property p_swap_rx;
    @(posedge core_clk) disable iff (srst)
    reset_source_aux[BIT_UART0_SWAP]
      && !(wr_pend && wr_ok && (wr_idx == IDX_AUX))
      |=> uart0_rxd == $past(p06_in) && p07_oe;
  endproperty
  a_swap_rx: assert property (p_swap_rx)
    else $error("uart0 swap routing wrong");

  property p_trigger_done;
    @(posedge core_clk) disable iff (srst)
    prog_trigger && prog_done |=> !prog_trigger;
  endproperty
  a_trigger_done: assert property (p_trigger_done)
    else $error("trigger did not clear");
endmodule // scb_bank

// ### dv/scb_bank_tb.sv
// Self-checking bench for the system control register bank.
// Assumes scb_pkg and scb_bank are compiled first; one 100 MHz clock.
module scb_bank_tb
  import scb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, trig, osc, boot, srq, ovr, rxd;
  logic p06_out, p07_out, p06_oe, p07_oe;
  logic [31:0] hrdata;
  logic [6:0] irq_req;
  logic [17:0] fl = 18'h0;
  logic [18:0] c = 19'h0;
  logic [31:0] seed = 32'hD72362D4;
  logic [7:0] ea, eb;
  int n_fail = 0;
  int checked = 0;
  //////////////////////////////////////////////////////////////////////
  // hready is the slave's own hreadyout; hsize fixed at word
  scb_bank scb_bank_i (.core_clk(core_clk), .srst(srst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pwm_event_flag(fl[0]),
    .capture_flags(fl[3:1]), .pin_flag_register(fl[11:4]),
    .i2c_event_flag(fl[12]), .i2c_timeout_flag(fl[13]),
    .wake_timer_flag(fl[14]), .timer3_overflow_flag(fl[15]),
    .uart1_tx_done_flag(fl[16]), .uart1_rx_done_flag(fl[17]),
    .irq_req(irq_req), .prog_addr_oversize(c[0]),
    .prog_cmd_invalid(c[1]), .prog_block_locked(c[2]),
    .prog_done(c[3]), .prog_erase_active(c[4]), .below_brownout(c[5]),
    .brownout_prog_guard(c[6]), .brownout_detect_enable(c[7]),
    .brownout_reset_enable(c[8]), .prog_trigger(trig),
    .fast_internal_osc_on(osc), .boot_from_loader(boot),
    .soft_reset_req(srq), .port2_bit0(c[9]),
    .reset_pin_disable_cfg(c[10]), .soft_reset_event(c[11]),
    .pin_reset_event(c[12]), .pc_overrun(c[13]),
    .on_chip_debug_mode(c[14]), .debug_reset_allow(c[15]),
    .overrun_reset_req(ovr), .uart0_txd(c[16]), .p06_in(c[17]),
    .p07_in(c[18]), .uart0_rxd(rxd), .p06_out(p06_out),
    .p07_out(p07_out), .p06_oe(p06_oe), .p07_oe(p07_oe));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected request word, one term per source group
  function automatic logic [31:0] exp_irq(input logic [7:0] a, b,
    input logic [17:0] f);
    return {25'h0, b[0] & (f[16] | f[17]),
      b[1] & f[15],
      b[2] & f[14],
      a[0] & (f[12] | f[13]),
      a[1] & (|f[11:4]),
      a[2] & (|f[3:1]),
      a[3] & f[0]};
  endfunction
  task automatic end_sim;
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk(input string nm, input logic e, g);
    cmp(nm, {31'h0, e}, {31'h0, g});
  endtask
  // single ahb transfer; no wait count assumed, watchdog cuts hangs
  task automatic xfer(input logic w, input logic [7:0] a, d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, a, 2'h0};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, e);
    logic [31:0] q;
    xfer(1'b0, a, 8'h00, q);
    cmp(nm, {24'h0, e}, q);
    chk("hresp", 1'b0, hresp);
  endtask
  // one-cycle cause pulse, then the overrun reset request is checked
  task automatic pulse(input int b, input logic e);
    c[b] <= 1'b1;
    @(posedge core_clk);
    c[b] <= 1'b0;
    @(posedge core_clk);
    chk("overrun req", e, ovr);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
    forever #5 core_clk = ~core_clk;
  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    end_sim();
  end
  initial
  begin : main
    logic [7:0] rl [7] = '{IDX_ENABLE_A, IDX_ENABLE_B, IDX_CHIP_CONTROL,
      IDX_PORT2, IDX_AUX, IDX_PROG_TRIGGER, 8'h9D};
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    foreach (rl[i]) rd("reset value", rl[i], 8'h00);
    // sparse random flags so single sources are seen alone
    for (int i = 0; i < 48; i++)
    begin
      if (i % 8 == 0)
      begin
        seed = lf(seed);
        ea = seed[7:0];
        eb = seed[15:8] & ENABLE_B_MASK;
        wr(IDX_ENABLE_A, ea);
        wr(IDX_ENABLE_B, seed[15:8]);
        rd("enable b", IDX_ENABLE_B, eb);
      end
      seed = lf(seed);
      fl <= seed[17:0] & seed[31:14];
      repeat (2) @(posedge core_clk);
      cmp("irq_req", exp_irq(ea, eb, fl), {25'h0, irq_req});
    end
    for (int i = 0; i < 4; i++)
    begin
      c[10:9] <= i[1:0];
      rd("port2", IDX_PORT2, {7'h0, i[0] & !i[1]});
    end
    // swaps happen with no uart0 frame in flight
    wr(IDX_AUX, 8'hFF);
    rd("aux", IDX_AUX, 8'hEC);
    c[18:16] <= seed[2:0];
    repeat (2) @(posedge core_clk);
    chk("rxd", c[17], rxd);
    chk("p06_oe", 1'b0, p06_oe);
    chk("p07_out", c[16], p07_out);
    wr(IDX_AUX, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("rxd", c[18], rxd);
    chk("p07_oe", 1'b0, p07_oe);
    chk("p06_out", c[16], p06_out);
    wr(IDX_CHIP_CONTROL, 8'h03);
    repeat (2) @(posedge core_clk);
    chk("osc", 1'b1, osc);
    chk("boot", 1'b1, boot);
    // each of the three request faults in turn
    for (int k = 0; k < 3; k++)
    begin
      c[k] <= 1'b1;
      wr(IDX_PROG_TRIGGER, 8'h01);
      @(posedge core_clk);
      chk("trigger", 1'b1, trig);
      c[k] <= 1'b0;
      rd("trigger", IDX_PROG_TRIGGER, 8'h00);
      rd("chip", IDX_CHIP_CONTROL, 8'h43);
      c[3] <= 1'b1;
      repeat (2) @(posedge core_clk);
      chk("trigger", 1'b0, trig);
      c[3] <= 1'b0;
      wr(IDX_CHIP_CONTROL, 8'h43);
      rd("chip", IDX_CHIP_CONTROL, 8'h43);
      wr(IDX_CHIP_CONTROL, 8'h03);
      rd("chip", IDX_CHIP_CONTROL, 8'h03);
    end
    // brown-out hazard only counts with brown-out reset off
    c[8:4] <= 5'h1F;
    repeat (3) @(posedge core_clk);
    c[8:4] <= 5'h0F;
    rd("chip", IDX_CHIP_CONTROL, 8'h03);
    c[8:4] <= 5'h00;
    rd("chip", IDX_CHIP_CONTROL, 8'h43);
    wr(IDX_CHIP_CONTROL, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("osc", 1'b0, osc);
    chk("boot", 1'b0, boot);
    // software reset request is a one-cycle pulse, bit 7 reads 0
    wr(IDX_CHIP_CONTROL, 8'h80);
    @(posedge core_clk);
    chk("soft reset req", 1'b1, srq);
    @(posedge core_clk);
    chk("soft reset req", 1'b0, srq);
    rd("chip", IDX_CHIP_CONTROL, 8'h00);
    pulse(11, 1'b0);
    rd("aux", IDX_AUX, 8'h80);
    pulse(12, 1'b0);
    rd("aux", IDX_AUX, 8'hC0);
    pulse(13, 1'b1);
    rd("aux", IDX_AUX, 8'hE0);
    wr(IDX_AUX, 8'h00);
    c[15:14] <= 2'h1;
    @(posedge core_clk);
    pulse(13, 1'b0);
    rd("aux", IDX_AUX, 8'h20);
    end_sim();
  end
endmodule // scb_bank_tb
